// ---- design/rtb_pkg.sv ----
// rtb_pkg: register map, field layout, reset values and source codes
// of the real-time clock with backup registers.
// assumes: every user writes rtb_pkg::name, nothing is imported.
package rtb_pkg;

    // register byte offsets on the 8-bit apb address
    localparam logic [7:0] CTRL_OFS     = 8'h00;
    localparam logic [7:0] STAT_OFS     = 8'h04;
    localparam logic [7:0] PRL_OFS      = 8'h08;
    localparam logic [7:0] DIV_OFS      = 8'h0c;
    localparam logic [7:0] CNT_OFS      = 8'h10;
    localparam logic [7:0] ALR_OFS      = 8'h14;
    localparam logic [7:0] BKP_BASE_OFS = 8'h40;

    // backup register bank
    localparam int unsigned BKP_NUM     = 10;
    localparam int unsigned BKP_W       = 16;
    localparam logic [3:0]  BKP_LAST    = 4'h9;

    // control register fields
    localparam int unsigned CTRL_SEL_LSB  = 0;
    localparam int unsigned CTRL_SEL_MSB  = 1;
    localparam int unsigned CTRL_CAL_BIT  = 2;
    localparam logic [2:0]  CTRL_RST      = 3'h0;

    // status register fields, write one to clear
    localparam int unsigned STAT_ALR_BIT  = 0;
    localparam int unsigned STAT_SEC_BIT  = 1;
    localparam int unsigned STAT_OVF_BIT  = 2;
    localparam logic [2:0]  STAT_RST      = 3'h0;

    // prescaler and counter
    localparam int unsigned PRL_W   = 20;
    localparam logic [19:0] PRL_RST = 20'h07fff; // 32768 ticks per second
    localparam logic [31:0] CNT_RST = 32'h0000_0000;
    localparam logic [31:0] ALR_RST = 32'hffff_ffff;

    // clock source selection codes
    localparam logic [1:0] SEL_OFF = 2'h0;
    localparam logic [1:0] SEL_LSE = 2'h1;
    localparam logic [1:0] SEL_LSI = 2'h2;
    localparam logic [1:0] SEL_FXO = 2'h3;

    // fast external oscillator divided by 128
    localparam int unsigned FXO_DIV_W = 7;
    localparam logic [6:0]  FXO_LAST  = 7'h7f;

    // 512 Hz from 32.768 kHz: toggle every 32 input ticks
    localparam int unsigned CAL_W    = 5;
    localparam logic [4:0]  CAL_LAST = 5'h1f;

    // source pins handled by the front end
    localparam int unsigned SRC_NUM = 3;
    localparam int unsigned SRC_LSE = 0;
    localparam int unsigned SRC_LSI = 1;
    localparam int unsigned SRC_FXO = 2;

endpackage

// ---- design/rtb_src_if.sv ----
// rtb_src_if: link between the clock source front end and the rtc core.
// assumes: both ends run on the one system clock.
`timescale 1ns/100ps
`default_nettype none
interface rtb_src_if;
    logic [1:0] sel;     // selected source code
    logic       in_tick; // one-cycle pulse per selected input period

    modport core  (output sel, input  in_tick);
    modport front (input  sel, output in_tick);
endinterface
`default_nettype wire

// ---- design/rtb_src_sel.sv ----
// rtb_src_sel: synchronises the three source clocks, divides the
// fast external one by 128 and picks one as a tick enable.
// assumes: source clocks are well below half the system clock rate.
`timescale 1ns/100ps
`default_nettype none
module rtb_src_sel (
    input  wire logic                 clk,
    input  wire logic                 reset,
    input  wire logic                 lse_clk_pin,
    input  wire logic                 lsi_clk_pin,
    input  wire logic                 fxo_clk_pin,
    rtb_src_if.front                  src
);
    logic [rtb_pkg::SRC_NUM-1:0]    pin_vec;
    logic [rtb_pkg::SRC_NUM-1:0]    rise;
    logic [rtb_pkg::FXO_DIV_W-1:0]  fxo_div_r;
    logic                           tick_r;
    logic                           tick_nxt;

    assign pin_vec = {fxo_clk_pin, lsi_clk_pin, lse_clk_pin};

    // per source: two-flop synchroniser, then a history flop for edges
    genvar g;
    generate
        for (g = 0; g < rtb_pkg::SRC_NUM; g++) begin : g_sync
            logic meta_r;
            logic sync_r;
            logic hist_r;
            always_ff @(posedge clk) begin
                if (reset) begin
                    meta_r <= 1'b0;
                    sync_r <= 1'b0;
                    hist_r <= 1'b0;
                end else begin
                    meta_r <= pin_vec[g];
                    sync_r <= meta_r;
                    hist_r <= sync_r;
                end
            end
            // edge taken from the second stage only
            assign rise[g] = sync_r & ~hist_r;
        end
    endgenerate

    // divide the fast external clock by 128
    always_ff @(posedge clk) begin
        if (reset) begin
            fxo_div_r <= '0;
        end else if (rise[rtb_pkg::SRC_FXO]) begin
            fxo_div_r <= fxo_div_r + 1'b1;
        end
    end

    always_comb begin
        tick_nxt = 1'b0;
        unique case (src.sel)
            rtb_pkg::SEL_OFF: tick_nxt = 1'b0;
            rtb_pkg::SEL_LSE: tick_nxt = rise[rtb_pkg::SRC_LSE];
            rtb_pkg::SEL_LSI: tick_nxt = rise[rtb_pkg::SRC_LSI];
            rtb_pkg::SEL_FXO: tick_nxt = rise[rtb_pkg::SRC_FXO] &&
                                    (fxo_div_r == rtb_pkg::FXO_LAST);
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            tick_r <= 1'b0;
        end else begin
            tick_r <= tick_nxt;
        end
    end

    assign src.in_tick = tick_r;
endmodule
`default_nettype wire

// ---- design/rtb_rtc.sv ----
// rtb_rtc: real-time clock core with prescaler, counter, alarm,
// calibration output and ten backup registers behind an apb slave.
// assumes: apb master on clk; power controller signals on clk;
// source clocks and main power status arrive asynchronously.
//
// Notes on behaviour
// - ten 16-bit backup registers keep 20 bytes while main power is absent
// - counters run freely; alarm and periodic interrupt outputs provided
// - input clock selectable: slow crystal, low-power rc, fast clock /128
// - 512 Hz calibration output derived from the selected input clock
// - 32-bit programmable counter with compare register producing alarm
// - 20-bit prescaler, reset default gives one second from 32.768 kHz
// - clock keeps running in stop and standby modes
// - alarm drives an event line so it can wake from stop
// - alarm raises a wake request to leave standby
// - standby loses bus-side state but keeps all backup-domain state
//
// Chosen here: the placing of the registers and the APB slave port.
`timescale 1ns/100ps
`default_nettype none
module rtb_rtc (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        lse_clk_pin,
    input  wire logic        lsi_clk_pin,
    input  wire logic        fxo_clk_pin,
    input  wire logic        main_power_ok,
    input  wire logic        stop_mode,
    input  wire logic        standby_mode,
    output logic             cal_out,
    output logic             alarm_irq,
    output logic             second_irq,
    output logic             alarm_event_line,
    output logic             second_event,
    output logic             standby_wake
);
    rtb_src_if src ();

    logic [2:0]                    ctrl_r;
    logic [2:0]                    stat_r;
    logic [rtb_pkg::PRL_W-1:0]     prl_r;
    logic [rtb_pkg::PRL_W-1:0]     div_r;
    logic [31:0]                   cnt_r;
    logic [31:0]                   alr_r;
    logic [rtb_pkg::BKP_W-1:0]     bkp_r [rtb_pkg::BKP_NUM];
    logic [rtb_pkg::CAL_W-1:0]     cal_cnt_r;
    logic                          cal_out_r;
    logic                          tb_tick_r;
    logic                          cnt_upd_r;
    logic                          pwr_meta_r;
    logic                          pwr_sync_r;
    logic [31:0]                   prdata_r;
    logic [31:0]                   prdata_nxt;
    logic                          pready_r;
    logic                          pslverr_r;
    logic                          pslverr_nxt;
    logic                          alarm_ev_r;
    logic                          second_ev_r;
    logic                          wake_r;
    logic                          acc_wait;
    logic                          acc_done;
    logic                          wr_ok;
    logic                          bkp_hit;
    logic [3:0]                    bkp_idx;
    logic                          alarm_hit;
    logic                          cnt_wr;
    logic                          stat_wr;

    // clock source front end
    rtb_src_sel u_src (
        .clk         (clk),
        .reset       (reset),
        .lse_clk_pin (lse_clk_pin),
        .lsi_clk_pin (lsi_clk_pin),
        .fxo_clk_pin (fxo_clk_pin),
        .src         (src.front)
    );

    assign src.sel = ctrl_r[rtb_pkg::CTRL_SEL_MSB:rtb_pkg::CTRL_SEL_LSB];

    // main power status comes from the supervisor, asynchronous
    always_ff @(posedge clk) begin
        if (reset) begin
            pwr_meta_r <= 1'b0;
            pwr_sync_r <= 1'b0;
        end else begin
            pwr_meta_r <= main_power_ok;
            pwr_sync_r <= pwr_meta_r;
        end
    end

    // apb phases: one wait state, action on the edge pready is seen
    assign acc_wait = psel && penable && !pready_r;
    assign acc_done = psel && penable && pready_r;
    assign bkp_idx  = paddr[5:2];
    assign bkp_hit  = (paddr[7:6] == rtb_pkg::BKP_BASE_OFS[7:6]) &&
                      (paddr[1:0] == 2'h0) &&
                      (bkp_idx <= rtb_pkg::BKP_LAST);
    // no writes while main power is absent
    assign wr_ok    = acc_done && pwrite && !pslverr_r;
    assign cnt_wr   = wr_ok && (paddr == rtb_pkg::CNT_OFS);
    assign stat_wr  = wr_ok && (paddr == rtb_pkg::STAT_OFS);

    // read mux and error decode, sampled in the wait cycle
    always_comb begin
        prdata_nxt  = 32'h0000_0000;
        pslverr_nxt = 1'b0;
        if (bkp_hit) begin
            prdata_nxt = {16'h0000, bkp_r[bkp_idx]};
        end else begin
            unique case (paddr)
                rtb_pkg::CTRL_OFS: prdata_nxt = {29'h0, ctrl_r};
                rtb_pkg::STAT_OFS: prdata_nxt = {29'h0, stat_r};
                rtb_pkg::PRL_OFS:  prdata_nxt = {12'h000, prl_r};
                rtb_pkg::DIV_OFS:  prdata_nxt = {12'h000, div_r};
                rtb_pkg::CNT_OFS:  prdata_nxt = cnt_r;
                rtb_pkg::ALR_OFS:  prdata_nxt = alr_r;
                default:           pslverr_nxt = 1'b1;
            endcase
        end
        if (!pwr_sync_r) begin
            pslverr_nxt = 1'b1;
        end
        if (pslverr_nxt || pwrite) begin
            prdata_nxt = 32'h0000_0000;
        end
    end

    // bus answer state is core-domain and dropped in standby
    always_ff @(posedge clk) begin
        if (reset || standby_mode) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0000_0000;
        end else if (acc_wait) begin
            pready_r  <= 1'b1;
            pslverr_r <= pslverr_nxt;
            prdata_r  <= prdata_nxt;
        end else begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0000_0000;
        end
    end

    // control register: source and calibration enable
    always_ff @(posedge clk) begin
        if (reset) begin
            ctrl_r <= rtb_pkg::CTRL_RST;
        end else if (wr_ok && (paddr == rtb_pkg::CTRL_OFS)) begin
            ctrl_r <= pwdata[2:0];
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            prl_r <= rtb_pkg::PRL_RST;
        end else if (wr_ok && (paddr == rtb_pkg::PRL_OFS)) begin
            prl_r <= pwdata[rtb_pkg::PRL_W-1:0];
        end
    end

    // prescaler divider, not gated by stop or standby
    always_ff @(posedge clk) begin
        if (reset) begin
            div_r     <= rtb_pkg::PRL_RST;
            tb_tick_r <= 1'b0;
        end else if (wr_ok && (paddr == rtb_pkg::PRL_OFS)) begin
            // new reload starts at once, no wait for the old period
            div_r     <= pwdata[rtb_pkg::PRL_W-1:0];
            tb_tick_r <= 1'b0;
        end else if (src.in_tick) begin
            // reload on zero gives prl+1 inputs per tick
            if (div_r == '0) begin
                div_r     <= prl_r;
                tb_tick_r <= 1'b1;
            end else begin
                div_r     <= div_r - 1'b1;
                tb_tick_r <= 1'b0;
            end
        end else begin
            tb_tick_r <= 1'b0;
        end
    end

    // counter steps once per time-base tick
    always_ff @(posedge clk) begin
        if (reset) begin
            cnt_r     <= rtb_pkg::CNT_RST;
            cnt_upd_r <= 1'b0;
        end else if (cnt_wr) begin
            cnt_r     <= pwdata;
            cnt_upd_r <= 1'b1;
        end else if (tb_tick_r) begin
            cnt_r     <= cnt_r + 1'b1;
            cnt_upd_r <= 1'b1;
        end else begin
            cnt_upd_r <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            alr_r <= rtb_pkg::ALR_RST;
        end else if (wr_ok && (paddr == rtb_pkg::ALR_OFS)) begin
            alr_r <= pwdata;
        end
    end

    // match checked only once per new counter value
    assign alarm_hit = cnt_upd_r && (cnt_r == alr_r);

    // sticky flags, a set in the clearing cycle wins
    always_ff @(posedge clk) begin
        if (reset) begin
            stat_r <= rtb_pkg::STAT_RST;
        end else begin
            stat_r[rtb_pkg::STAT_ALR_BIT] <= alarm_hit ||
                (stat_r[rtb_pkg::STAT_ALR_BIT] &&
                 !(stat_wr && pwdata[rtb_pkg::STAT_ALR_BIT]));
            stat_r[rtb_pkg::STAT_SEC_BIT] <= tb_tick_r ||
                (stat_r[rtb_pkg::STAT_SEC_BIT] &&
                 !(stat_wr && pwdata[rtb_pkg::STAT_SEC_BIT]));
            stat_r[rtb_pkg::STAT_OVF_BIT] <=
                (tb_tick_r && !cnt_wr && (cnt_r == 32'hffff_ffff)) ||
                (stat_r[rtb_pkg::STAT_OVF_BIT] &&
                 !(stat_wr && pwdata[rtb_pkg::STAT_OVF_BIT]));
        end
    end

    // event pulses; wake request only while in standby
    always_ff @(posedge clk) begin
        if (reset) begin
            alarm_ev_r  <= 1'b0;
            second_ev_r <= 1'b0;
            wake_r      <= 1'b0;
        end else begin
            alarm_ev_r  <= alarm_hit;
            second_ev_r <= tb_tick_r;
            wake_r      <= alarm_hit && standby_mode;
        end
    end

    // 512 Hz: half period is 32 input ticks of 32.768 kHz
    always_ff @(posedge clk) begin
        if (reset) begin
            cal_cnt_r <= '0;
            cal_out_r <= 1'b0;
        end else if (!ctrl_r[rtb_pkg::CTRL_CAL_BIT]) begin
            cal_cnt_r <= '0;
            cal_out_r <= 1'b0;
        end else if (src.in_tick) begin
            cal_cnt_r <= cal_cnt_r + 1'b1;
            if (cal_cnt_r == rtb_pkg::CAL_LAST) begin
                cal_out_r <= !cal_out_r;
            end
        end
    end

    // backup bank, one word per entry; reset only at domain reset
    genvar b;
    generate
        for (b = 0; b < rtb_pkg::BKP_NUM; b++) begin : g_bkp
            always_ff @(posedge clk) begin
                if (reset) begin
                    bkp_r[b] <= '0;
                end else if (wr_ok && bkp_hit &&
                             (bkp_idx == 4'(b))) begin
                    bkp_r[b] <= pwdata[rtb_pkg::BKP_W-1:0];
                end
            end
        end
    endgenerate

    // stop_mode is accepted for completeness: nothing here halts on it
    logic unused_stop;
    assign unused_stop = stop_mode;

    assign prdata           = prdata_r;
    assign pready           = pready_r;
    assign pslverr          = pslverr_r;
    assign cal_out          = cal_out_r;
    assign alarm_irq        = stat_r[rtb_pkg::STAT_ALR_BIT];
    assign second_irq       = stat_r[rtb_pkg::STAT_SEC_BIT];
    assign alarm_event_line = alarm_ev_r;
    assign second_event     = second_ev_r;
    assign standby_wake     = wake_r;
endmodule
`default_nettype wire

// ---- testbench/rtb_rtc_chk.sv ----
// rtb_rtc_chk: concurrent checks on the rtc core top ports.
// assumes: bound into rtb_rtc, one clock, sync active-high reset.
`timescale 1ns/100ps
`default_nettype none
module rtb_rtc_chk (
    input wire logic        clk,
    input wire logic        reset,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        main_power_ok,
    input wire logic        standby_mode,
    input wire logic        alarm_irq,
    input wire logic        second_irq,
    input wire logic        alarm_event_line,
    input wire logic        second_event,
    input wire logic        standby_wake
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    // bus answer shape: one wait state, one-cycle strobe
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready stood longer than one cycle");
    a_ready_timing: assert property (
        (psel && !penable && !standby_mode) ##1
        (psel && penable && !standby_mode) |=> (pready || standby_mode))
        else $error("pready missing in second access cycle");
    a_ready_access: assert property (pready |-> psel && penable)
        else $error("pready outside an access phase");
    // read data is zero unless a read is answered
    a_rdata_idle: assert property ((!pready || pwrite) |-> prdata == '0)
        else $error("prdata not zero outside a read answer");
    // backup side refuses bus access without main power
    a_err_nopower: assert property (
        pready && !$past(main_power_ok, 3) && !$past(main_power_ok, 4)
        && !$past(main_power_ok, 5) |-> pslverr)
        else $error("access without main power not refused");
    // time base tick is a single pulse and sets the periodic flag
    a_second_pulse: assert property (second_event |=> !second_event)
        else $error("second_event longer than one cycle");
    a_second_flag: assert property (second_event |-> ##[0:2] second_irq)
        else $error("second_irq not raised after tick");
    a_alarm_flag: assert property (alarm_event_line |-> alarm_irq)
        else $error("alarm event without alarm flag");
    // wake only comes out of standby, together with the alarm
    a_wake_standby: assert property (
        standby_wake |-> (standby_mode || $past(standby_mode))
        ##0 (##[0:1] alarm_irq))
        else $error("standby_wake without standby and alarm");
endmodule

bind rtb_rtc rtb_rtc_chk chk (
    .clk              (clk),
    .reset            (reset),
    .psel             (psel),
    .penable          (penable),
    .pwrite           (pwrite),
    .prdata           (prdata),
    .pready           (pready),
    .pslverr          (pslverr),
    .main_power_ok    (main_power_ok),
    .standby_mode     (standby_mode),
    .alarm_irq        (alarm_irq),
    .second_irq       (second_irq),
    .alarm_event_line (alarm_event_line),
    .second_event     (second_event),
    .standby_wake     (standby_wake)
);
`default_nettype wire

// ---- testbench/rtb_rtc_bench.sv ----
// rtb_rtc_bench: self-checking bench for the rtc core.
// assumes: bench is apb master, source pins and power controller.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, got) begin checks_done++; \
    if ((got) !== (ex)) begin bad_count++; \
    $display("MISMATCH %s expected %0h seen %0h", nm, ex, got); end end
module rtb_rtc_bench;
    logic        clk = 1'b0;
    logic        reset = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [2:0]  pins = 3'h0;
    logic        power_ok = 1'b1;
    logic        stop_mode = 1'b0;
    logic        standby_mode = 1'b0;
    logic        cal_out;
    logic        alarm_irq;
    logic        second_irq;
    logic        alarm_ev;
    logic        second_ev;
    logic        wake;
    logic        cal_prev = 1'b0;
    int          bad_count = 0;
    int          checks_done = 0;
    int          cycles = 0;
    int          n_sec = 0;
    int          n_alarm = 0;
    int          n_wake = 0;
    int          n_cal = 0;

    rtb_rtc dut (
        .clk(clk), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .lse_clk_pin(pins[rtb_pkg::SRC_LSE]),
        .lsi_clk_pin(pins[rtb_pkg::SRC_LSI]),
        .fxo_clk_pin(pins[rtb_pkg::SRC_FXO]),
        .main_power_ok(power_ok), .stop_mode(stop_mode),
        .standby_mode(standby_mode), .cal_out(cal_out),
        .alarm_irq(alarm_irq), .second_irq(second_irq),
        .alarm_event_line(alarm_ev), .second_event(second_ev),
        .standby_wake(wake)
    );

    always #5 clk = ~clk;

    // event counters; also cuts a hang short
    always @(posedge clk) begin
        cycles++;
        if (second_ev === 1'b1) n_sec++;
        if (alarm_ev === 1'b1) n_alarm++;
        if (wake === 1'b1) n_wake++;
        if (cal_out !== cal_prev) n_cal++;
        cal_prev = cal_out;
        if (cycles == 20000) begin
            bad_count++;
            test_done();
        end
    end

    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // one apb transfer; waits for pready, bounded
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q,
                       output logic e);
        int n;
        @(posedge clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        q = prdata;
        e = pslverr;
        if (n >= 50) `CHK("pready", 1'b1, pready)
        psel <= 1'b0; penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'b1, a, d, q, e);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] ex);
        logic [31:0] q;
        logic        e;
        apb(1'b0, a, 32'h0, q, e);
        `CHK("prdata", ex, q)
    endtask

    task automatic refused(input logic w, input logic [7:0] a);
        logic [31:0] q;
        logic        e;
        apb(w, a, 32'hffff_ffff, q, e);
        `CHK("pslverr", 1'b1, e)
    endtask

    // n rising edges on one source pin, then settle
    task automatic pulse(input int s, input int n);
        repeat (n) begin
            @(posedge clk) pins[s] <= 1'b1;
            repeat (3) @(posedge clk);
            pins[s] <= 1'b0;
            repeat (3) @(posedge clk);
        end
        repeat (8) @(posedge clk);
    endtask

    // run inputs until one tick, so divider phase is known
    task automatic sync_tick(input int s);
        int k;
        int n0;
        n0 = n_sec;
        k = 0;
        while (n_sec == n0 && k < 40) begin
            pulse(s, 1);
            k++;
        end
        `CHK("sync tick", 1'b1, n_sec != n0)
    endtask

    task automatic t_reset();
        rd(rtb_pkg::CTRL_OFS, 32'h0);
        rd(rtb_pkg::STAT_OFS, 32'h0);
        rd(rtb_pkg::PRL_OFS, {12'h0, rtb_pkg::PRL_RST});
        wr(rtb_pkg::DIV_OFS, 32'h5);
        rd(rtb_pkg::DIV_OFS, {12'h0, rtb_pkg::PRL_RST});
        rd(rtb_pkg::CNT_OFS, rtb_pkg::CNT_RST);
        rd(rtb_pkg::ALR_OFS, rtb_pkg::ALR_RST);
        $display("test reset values done");
    endtask

    task automatic t_backup();
        for (int i = 0; i < 10; i++)
            wr(rtb_pkg::BKP_BASE_OFS + 8'(i * 4), {20'hffff5, 12'(i)});
        for (int i = 0; i < 10; i++)
            rd(rtb_pkg::BKP_BASE_OFS + 8'(i * 4), {20'h5, 12'(i)});
        refused(1'b1, 8'h68);
        refused(1'b0, 8'h42);
        power_ok <= 1'b0;
        repeat (6) @(posedge clk);
        refused(1'b1, rtb_pkg::BKP_BASE_OFS);
        power_ok <= 1'b1;
        standby_mode <= 1'b1;
        repeat (6) @(posedge clk);
        standby_mode <= 1'b0;
        rd(rtb_pkg::BKP_BASE_OFS, 32'h5000);
        rd(8'h64, 32'h5009);
        $display("test backup done");
    endtask

    task automatic t_sources();
        wr(rtb_pkg::PRL_OFS, 32'h0);
        wr(rtb_pkg::CTRL_OFS, {30'h0, rtb_pkg::SEL_LSE});
        sync_tick(rtb_pkg::SRC_LSE);
        wr(rtb_pkg::CTRL_OFS, {30'h0, rtb_pkg::SEL_LSI});
        wr(rtb_pkg::CNT_OFS, 32'h0);
        pulse(rtb_pkg::SRC_LSI, 3);
        pulse(rtb_pkg::SRC_LSE, 3);
        rd(rtb_pkg::CNT_OFS, 32'h3);
        wr(rtb_pkg::CTRL_OFS, {30'h0, rtb_pkg::SEL_FXO});
        wr(rtb_pkg::CNT_OFS, 32'h0);
        pulse(rtb_pkg::SRC_FXO, 256);
        rd(rtb_pkg::CNT_OFS, 32'h2);
        wr(rtb_pkg::CTRL_OFS, {30'h0, rtb_pkg::SEL_OFF});
        wr(rtb_pkg::CNT_OFS, 32'h0);
        pulse(rtb_pkg::SRC_LSE, 3);
        rd(rtb_pkg::CNT_OFS, 32'h0);
        $display("test sources done");
    endtask

    task automatic t_counter();
        int n0;
        wr(rtb_pkg::PRL_OFS, 32'h3);
        wr(rtb_pkg::CTRL_OFS, {30'h0, rtb_pkg::SEL_LSE});
        sync_tick(rtb_pkg::SRC_LSE);
        wr(rtb_pkg::CNT_OFS, 32'h0);
        wr(rtb_pkg::STAT_OFS, 32'h7);
        n0 = n_sec;
        pulse(rtb_pkg::SRC_LSE, 8);
        rd(rtb_pkg::CNT_OFS, 32'h2);
        `CHK("ticks", 2, n_sec - n0)
        rd(rtb_pkg::STAT_OFS, 32'h2);
        wr(rtb_pkg::STAT_OFS, 32'h2);
        rd(rtb_pkg::STAT_OFS, 32'h0);
        stop_mode <= 1'b1;
        wr(rtb_pkg::CNT_OFS, 32'h0);
        pulse(rtb_pkg::SRC_LSE, 4);
        rd(rtb_pkg::CNT_OFS, 32'h1);
        stop_mode <= 1'b0;
        $display("test counter done");
    endtask

    task automatic t_alarm();
        int a0;
        int w0;
        wr(rtb_pkg::ALR_OFS, 32'h6);
        wr(rtb_pkg::CNT_OFS, 32'h4);
        wr(rtb_pkg::STAT_OFS, 32'h7);
        a0 = n_alarm;
        w0 = n_wake;
        standby_mode <= 1'b1;
        pulse(rtb_pkg::SRC_LSE, 8);
        standby_mode <= 1'b0;
        rd(rtb_pkg::CNT_OFS, 32'h6);
        `CHK("alarm_irq", 1'b1, alarm_irq)
        `CHK("alarm events", 1, n_alarm - a0)
        `CHK("wake pulses", 1, n_wake - w0)
        wr(rtb_pkg::STAT_OFS, 32'h3);
        rd(rtb_pkg::STAT_OFS, 32'h0);
        `CHK("alarm_irq", 1'b0, alarm_irq)
        wr(rtb_pkg::CNT_OFS, 32'hffff_ffff);
        pulse(rtb_pkg::SRC_LSE, 4);
        rd(rtb_pkg::CNT_OFS, 32'h0);
        rd(rtb_pkg::STAT_OFS, 32'h6);
        $display("test alarm done");
    endtask

    task automatic t_cal();
        int c0;
        wr(rtb_pkg::CTRL_OFS, {29'h0, 1'b1, rtb_pkg::SEL_LSE});
        // enabling starts from a cleared count and a low output; count from after that
        repeat (4) @(posedge clk);
        c0 = n_cal;
        pulse(rtb_pkg::SRC_LSE, 64);
        `CHK("cal toggles", 2, n_cal - c0)
        wr(rtb_pkg::CTRL_OFS, {30'h0, rtb_pkg::SEL_LSE});
        repeat (3) @(posedge clk);
        `CHK("cal_out", 1'b0, cal_out)
        $display("test calibration done");
    endtask

    // main sequence
    initial begin
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        repeat (4) @(posedge clk);
        t_reset();
        t_backup();
        t_sources();
        t_counter();
        t_alarm();
        t_cal();
        test_done();
    end
endmodule
`undef CHK
`default_nettype wire
